// [sscc_pkg.sv]
// shared constants for the spi shift and clock core
package sscc_pkg;
   localparam int          SSCC_CHAR_BITS     = 8;
   localparam int          SSCC_SYNC_STAGES   = 3;
   localparam int          SSCC_BRG_WIDTH     = 16;
   localparam logic [15:0] SSCC_BRG_RESET     = 16'h0004;
   localparam logic [2:0]  SSCC_LEN_RESET     = 3'h0;
   localparam logic [7:0]  SSCC_DATA_RESET    = 8'h00;
   localparam int          SSCC_CLK_PERIOD_NS = 20;
   localparam int          SSCC_SLAVE_MIN_SCK_CLKS = 8;
   localparam int          SSCC_SLAVE_MIN_SCK_NS   = 160;
   localparam int          SSCC_SLAVE_SCK_CYCLES =
      (SSCC_SLAVE_MIN_SCK_NS + SSCC_CLK_PERIOD_NS - 1) / SSCC_CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      SSCC_IDLE  = 3'b001,
      SSCC_LEAD  = 3'b010,
      SSCC_TRAIL = 3'b100
   } sscc_state_type;
endpackage

// [sscc_sync.sv]
// three-stage synchroniser with second/third stage agreement
`timescale 1ns/1ps
module sscc_sync #(
   parameter logic RESET_VALUE = 1'b1
) (
   input  wire logic clock,     // system clock
   input  wire logic arst_n,    // async reset, active low
   input  wire logic async_in,  // pin level
   output logic      sync_out   // filtered level
);
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic       out_reg;
   logic       out_next;

   always_comb begin
      stage_next = {stage_reg[1:0], async_in};
      // stage 0 only feeds stage 1
      out_next   = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : out_reg;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stage_reg <= {3{RESET_VALUE}};
         out_reg   <= RESET_VALUE;
      end else begin
         stage_reg <= stage_next;
         out_reg   <= out_next;
      end
   end

   assign sync_out = out_reg;
endmodule // sscc_sync

// [sscc_brg.sv]
// baud-rate generator: one tick every reload clocks while running
`timescale 1ns/1ps
module sscc_brg #(
   parameter int WIDTH = sscc_pkg::SSCC_BRG_WIDTH
) (
   input  wire logic             clock,   // system clock
   input  wire logic             arst_n,  // async reset, active low
   input  wire logic             run,     // count while high
   input  wire logic [WIDTH-1:0] reload,  // half-period in clocks
   output logic                  tick     // one-cycle pulse
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   logic             tick_reg;
   logic             tick_next;

   always_comb begin
      count_next = count_reg;
      tick_next  = 1'b0;
      if (!run) begin
         count_next = reload;
      end else if (count_reg <= WIDTH'(1)) begin
         // zero reload ticks every clock, same as a reload of one
         count_next = reload;
         tick_next  = 1'b1;
      end else begin
         count_next = count_reg - WIDTH'(1);
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         count_reg <= '0;
         tick_reg  <= 1'b0;
      end else begin
         count_reg <= count_next;
         tick_reg  <= tick_next;
      end
   end

   assign tick = tick_reg;
endmodule // sscc_brg

// [sscc_core.sv]
// spi shift register, clock generation and slave-select handling
`timescale 1ns/1ps
// Summary of operation
// - one 8-bit register shifts out and in
// - single buffered; load only when idle
// - miso input as master, output as slave
// - slave releases miso unselected or disabled
// - mosi driven as master, released disabled
// - master makes sck from baud generator
// - slave ignores sck while not selected
// - character spans char_length_field sck cycles, 8 when the field is 0
// - shift one edge, sample the other
// - sole master: select pin input or output
// - multi-master select low sets collision flag
// - polarity only inverts clock idle level
// - four phase/polarity edge formats applied
// - master data leads receive edge half-cycle
// - both ends share phase and polarity
// - character length 1 to 8 bits
// - write during transfer dropped, sets overrun
module sscc_core #(
   parameter int BRG_WIDTH = sscc_pkg::SSCC_BRG_WIDTH
) (
   input  wire logic                 CLOCK,        // 50 mhz system clock
   input  wire logic                 ARST_N,       // async reset, active low
   input  wire logic                 ENABLE,       // spi function enable
   input  wire logic                 MASTER,       // 1 master, 0 slave
   input  wire logic                 MULTI_MASTER, // select pin watched
   input  wire logic                 SS_OUTPUT,    // sole master drives ss
   input  wire logic                 SS_VALUE,     // level driven on ss
   input  wire logic                 PHASE,        // transfer format
   input  wire logic                 CLOCK_POLARITY_BIT, // sck idle level
   input  wire logic [2:0]           CHAR_LENGTH_FIELD,  // 0 means 8 bits
   input  wire logic [BRG_WIDTH-1:0] BRG_RELOAD,   // half sck period
   input  wire logic [7:0]           WR_DATA,      // data to load
   input  wire logic                 WR_STROBE,    // load pulse
   input  wire logic                 OVR_CLEAR,    // clear overrun pulse
   input  wire logic                 COL_CLEAR,    // clear collision pulse
   input  wire logic                 RD_ACK,       // received data read
   input  wire logic                 SCK_IN,       // sck pin level
   input  wire logic                 SS_N_IN,      // ss pin level
   input  wire logic                 MOSI_IN,      // mosi pin level
   input  wire logic                 MISO_IN,      // miso pin level
   output logic                      SCK_OUT,      // sck drive value
   output logic                      SCK_OE,       // sck drive enable
   output logic                      SS_N_OUT,     // ss drive value
   output logic                      SS_N_OE,      // ss drive enable
   output logic                      MOSI_OUT,     // mosi drive value
   output logic                      MOSI_OE,      // mosi drive enable
   output logic                      MISO_OUT,     // miso drive value
   output logic                      MISO_OE,      // miso drive enable
   output logic [7:0]                RD_DATA,      // shift register contents
   output logic                      BUSY,         // transfer in progress
   output logic                      DONE,         // character complete pulse
   output logic                      RX_FULL,      // received data unread
   output logic                      OVERRUN_FLAG, // write during transfer
   output logic                      COLLISION_FLAG // multi-master fault
);
   logic sck_s;
   logic ss_n_s;
   logic mosi_s;
   logic miso_s;
   logic brg_tick;

   sscc_sync #(.RESET_VALUE(1'b0)) u_sync_sck (
      .clock(CLOCK), .arst_n(ARST_N), .async_in(SCK_IN), .sync_out(sck_s));
   sscc_sync #(.RESET_VALUE(1'b1)) u_sync_ss (
      .clock(CLOCK), .arst_n(ARST_N), .async_in(SS_N_IN), .sync_out(ss_n_s));
   sscc_sync #(.RESET_VALUE(1'b0)) u_sync_mosi (
      .clock(CLOCK), .arst_n(ARST_N), .async_in(MOSI_IN), .sync_out(mosi_s));
   sscc_sync #(.RESET_VALUE(1'b0)) u_sync_miso (
      .clock(CLOCK), .arst_n(ARST_N), .async_in(MISO_IN), .sync_out(miso_s));

   sscc_pkg::sscc_state_type state_reg;
   sscc_pkg::sscc_state_type state_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [3:0] bits_reg;
   logic [3:0] bits_next;
   logic       sck_reg;
   logic       sck_next;
   logic       sck_prev_reg;
   logic       sck_prev_next;
   logic       out_bit_reg;
   logic       out_bit_next;
   logic       rx_full_reg;
   logic       rx_full_next;
   logic       ovr_reg;
   logic       ovr_next;
   logic       col_reg;
   logic       col_next;
   logic       done_reg;
   logic       done_next;
   logic       sck_oe_reg;
   logic       sck_oe_next;
   logic       ss_out_reg;
   logic       ss_out_next;
   logic       ss_oe_reg;
   logic       ss_oe_next;
   logic       mosi_oe_reg;
   logic       mosi_oe_next;
   logic       miso_oe_reg;
   logic       miso_oe_next;
   logic       busy_reg;
   logic       busy_next;

   logic       master_run;
   logic [3:0] char_len;
   logic       lead_edge;
   logic       trail_edge;
   logic       selected;
   logic       busy;

   assign master_run = ENABLE && MASTER &&
                       (state_reg != sscc_pkg::SSCC_IDLE);

   sscc_brg #(.WIDTH(BRG_WIDTH)) u_brg (
      .clock(CLOCK), .arst_n(ARST_N), .run(master_run),
      .reload(BRG_RELOAD), .tick(brg_tick));

   // zero field selects a full byte
   assign char_len = (CHAR_LENGTH_FIELD == 3'h0) ?
                     4'h8 : {1'b0, CHAR_LENGTH_FIELD};
   assign busy     = (state_reg != sscc_pkg::SSCC_IDLE);
   assign selected = !ss_n_s;

   // slave edges: leading edge leaves idle level, trailing returns
   always_comb begin
      lead_edge  = 1'b0;
      trail_edge = 1'b0;
      // same phase and polarity decode as the far master expects
      if (!MASTER && selected && (sck_s != sck_prev_reg)) begin
         // polarity only says which level is idle
         lead_edge  = (sck_prev_reg == CLOCK_POLARITY_BIT);
         trail_edge = !lead_edge;
      end
   end

   always_comb begin
      state_next    = state_reg;
      shift_next    = shift_reg;
      bits_next     = bits_reg;
      sck_next      = sck_reg;
      sck_prev_next = sck_s;
      out_bit_next  = out_bit_reg;
      rx_full_next  = rx_full_reg && !RD_ACK;
      ovr_next      = ovr_reg && !OVR_CLEAR;
      col_next      = col_reg && !COL_CLEAR;
      done_next     = 1'b0;

      // load only while idle and nothing unread
      if (WR_STROBE) begin
         if (busy) begin
            ovr_next = 1'b1;
         end else if (!rx_full_reg || RD_ACK) begin
            shift_next   = WR_DATA;
            out_bit_next = WR_DATA[7];
            if (ENABLE && MASTER) begin
               state_next = sscc_pkg::SSCC_LEAD;
               bits_next  = 4'h0;
               sck_next   = CLOCK_POLARITY_BIT;
            end
         end
      end

      if (ENABLE && MASTER && MULTI_MASTER && selected) begin
         col_next = 1'b1;
      end

      if (!ENABLE) begin
         state_next = sscc_pkg::SSCC_IDLE;
         sck_next   = CLOCK_POLARITY_BIT;
      end else if (MASTER) begin
         case (state_reg)
            sscc_pkg::SSCC_IDLE: begin
               if (!WR_STROBE) begin
                  sck_next = CLOCK_POLARITY_BIT;
               end
            end
            sscc_pkg::SSCC_LEAD: begin
               if (brg_tick) begin
                  sck_next   = !sck_reg;
                  state_next = sscc_pkg::SSCC_TRAIL;
                  if (PHASE) begin
                     // phase 1 shifts on leading edge
                     out_bit_next = shift_reg[7];
                  end else begin
                     shift_next = {shift_reg[6:0], miso_s};
                  end
               end
            end
            sscc_pkg::SSCC_TRAIL: begin
               if (brg_tick) begin
                  sck_next  = !sck_reg;
                  bits_next = bits_reg + 4'h1;
                  if (PHASE) begin
                     shift_next = {shift_reg[6:0], miso_s};
                  end else begin
                     out_bit_next = shift_reg[7];
                  end
                  if (bits_reg + 4'h1 == char_len) begin
                     state_next   = sscc_pkg::SSCC_IDLE;
                     done_next    = 1'b1;
                     rx_full_next = 1'b1;
                  end else begin
                     state_next = sscc_pkg::SSCC_LEAD;
                  end
               end
            end
            default: state_next = sscc_pkg::SSCC_IDLE;
         endcase
      end else begin
         // slave: busy from first edge to last bit or deselect
         if (!selected) begin
            state_next   = sscc_pkg::SSCC_IDLE;
            bits_next    = 4'h0;
            out_bit_next = shift_reg[7];
         end else if (lead_edge) begin
            state_next = sscc_pkg::SSCC_TRAIL;
            if (PHASE) begin
               out_bit_next = shift_reg[7];
            end else begin
               shift_next = {shift_reg[6:0], mosi_s};
            end
         end else if (trail_edge) begin
            bits_next = bits_reg + 4'h1;
            if (PHASE) begin
               shift_next = {shift_reg[6:0], mosi_s};
            end else begin
               out_bit_next = shift_reg[7];
            end
            if (bits_reg + 4'h1 == char_len) begin
               state_next   = sscc_pkg::SSCC_IDLE;
               bits_next    = 4'h0;
               done_next    = 1'b1;
               rx_full_next = 1'b1;
            end
         end
      end

      sck_oe_next  = ENABLE && MASTER;
      mosi_oe_next = ENABLE && MASTER;
      miso_oe_next = ENABLE && !MASTER && selected;
      ss_oe_next   = ENABLE && MASTER && !MULTI_MASTER && SS_OUTPUT;
      ss_out_next  = SS_VALUE;
      // registered copy keeps the busy pin glitch free
      busy_next    = (state_next != sscc_pkg::SSCC_IDLE);
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_reg    <= sscc_pkg::SSCC_IDLE;
         shift_reg    <= sscc_pkg::SSCC_DATA_RESET;
         bits_reg     <= 4'h0;
         sck_reg      <= 1'b0;
         sck_prev_reg <= 1'b0;
         out_bit_reg  <= 1'b0;
         rx_full_reg  <= 1'b0;
         ovr_reg      <= 1'b0;
         col_reg      <= 1'b0;
         done_reg     <= 1'b0;
         sck_oe_reg   <= 1'b0;
         ss_out_reg   <= 1'b1;
         ss_oe_reg    <= 1'b0;
         mosi_oe_reg  <= 1'b0;
         miso_oe_reg  <= 1'b0;
         busy_reg     <= 1'b0;
      end else begin
         state_reg    <= state_next;
         shift_reg    <= shift_next;
         bits_reg     <= bits_next;
         sck_reg      <= sck_next;
         sck_prev_reg <= sck_prev_next;
         out_bit_reg  <= out_bit_next;
         rx_full_reg  <= rx_full_next;
         ovr_reg      <= ovr_next;
         col_reg      <= col_next;
         done_reg     <= done_next;
         sck_oe_reg   <= sck_oe_next;
         ss_out_reg   <= ss_out_next;
         ss_oe_reg    <= ss_oe_next;
         mosi_oe_reg  <= mosi_oe_next;
         miso_oe_reg  <= miso_oe_next;
         busy_reg     <= busy_next;
      end
   end

   assign SCK_OUT        = sck_reg;
   assign SCK_OE         = sck_oe_reg;
   assign SS_N_OUT       = ss_out_reg;
   assign SS_N_OE        = ss_oe_reg;
   assign MOSI_OUT       = out_bit_reg;
   assign MOSI_OE        = mosi_oe_reg;
   assign MISO_OUT       = out_bit_reg;
   assign MISO_OE        = miso_oe_reg;
   assign RD_DATA        = shift_reg;
   assign BUSY           = busy_reg;
   assign DONE           = done_reg;
   assign RX_FULL        = rx_full_reg;
   assign OVERRUN_FLAG   = ovr_reg;
   assign COLLISION_FLAG = col_reg;
endmodule // sscc_core

// [sscc_core_chk.sv]
// port assertions for the spi shift and clock core
`timescale 1ns/1ps
module sscc_core_chk (
   input wire logic CLOCK,              // clock
   input wire logic ARST_N,             // reset
   input wire logic ENABLE,             // enable
   input wire logic MASTER,             // mode
   input wire logic MULTI_MASTER,       // watch ss
   input wire logic SS_OUTPUT,          // ss driven
   input wire logic PHASE,              // format
   input wire logic CLOCK_POLARITY_BIT, // idle level
   input wire logic WR_STROBE,          // load
   input wire logic RX_FULL,            // unread
   input wire logic SS_N_IN,            // ss pin
   input wire logic SCK_OUT,            // sck value
   input wire logic SCK_OE,             // sck enable
   input wire logic MOSI_OUT,           // mosi value
   input wire logic MOSI_OE,            // mosi enable
   input wire logic MISO_OE,            // miso enable
   input wire logic BUSY,               // busy
   input wire logic DONE,               // done
   input wire logic OVERRUN_FLAG,       // overrun
   input wire logic COLLISION_FLAG      // collision
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   property p_off;
      !ENABLE && $past(!ENABLE) |-> !MISO_OE && !MOSI_OE;
   endproperty
   a_off: assert property (p_off) else $error("pins driven when off");
   property p_mdrive;
      ENABLE && MASTER && $past(ENABLE && MASTER)
         |-> MOSI_OE && SCK_OE && !MISO_OE;
   endproperty
   a_mdrive: assert property (p_mdrive) else $error("master pins");
   property p_sdrive;
      !MASTER && $past(!MASTER) |-> !MOSI_OE && !SCK_OE;
   endproperty
   a_sdrive: assert property (p_sdrive) else $error("slave pins");
   // eight clocks cover the select synchroniser
   property p_unsel;
      (!MASTER && SS_N_IN) [*8] |-> !MISO_OE && !BUSY;
   endproperty
   a_unsel: assert property (p_unsel) else $error("unselected slave");
   property p_start;
      WR_STROBE && ENABLE && MASTER && !BUSY && !RX_FULL |=> BUSY;
   endproperty
   a_start: assert property (p_start) else $error("no start");
   property p_ovr;
      WR_STROBE && BUSY |=> OVERRUN_FLAG;
   endproperty
   a_ovr: assert property (p_ovr) else $error("no overrun");
   property p_col;
      (ENABLE && MASTER && MULTI_MASTER && !SS_OUTPUT && !SS_N_IN) [*6]
         |=> COLLISION_FLAG;
   endproperty
   a_col: assert property (p_col) else $error("no collision");
   property p_idle;
      DONE && MASTER |-> SCK_OUT == CLOCK_POLARITY_BIT && !BUSY;
   endproperty
   a_idle: assert property (p_idle) else $error("sck idle level");
   property p_lead;
      MASTER && BUSY && $changed(SCK_OUT)
         && (SCK_OUT ^ CLOCK_POLARITY_BIT ^ PHASE) |-> $stable(MOSI_OUT);
   endproperty
   a_lead: assert property (p_lead) else $error("mosi moved");
   c_ph1: cover property (DONE && PHASE);
   c_ovr: cover property ($rose(OVERRUN_FLAG));
   c_col: cover property ($rose(COLLISION_FLAG));
endmodule // sscc_core_chk

bind sscc_core sscc_core_chk i_chk (
   .CLOCK(CLOCK), .ARST_N(ARST_N), .ENABLE(ENABLE), .MASTER(MASTER),
   .MULTI_MASTER(MULTI_MASTER), .SS_OUTPUT(SS_OUTPUT), .PHASE(PHASE),
   .CLOCK_POLARITY_BIT(CLOCK_POLARITY_BIT), .WR_STROBE(WR_STROBE),
   .RX_FULL(RX_FULL), .SS_N_IN(SS_N_IN), .SCK_OUT(SCK_OUT),
   .SCK_OE(SCK_OE), .MOSI_OUT(MOSI_OUT), .MOSI_OE(MOSI_OE),
   .MISO_OE(MISO_OE), .BUSY(BUSY), .DONE(DONE),
   .OVERRUN_FLAG(OVERRUN_FLAG), .COLLISION_FLAG(COLLISION_FLAG)
);

// [sscc_slave_model.sv]
// behavioural spi slave facing the core in master mode
`timescale 1ns/1ps
module sscc_slave_model (
   input wire logic       sck,   // clock pin
   input wire logic       ss_n,  // select pin
   input wire logic       mosi,  // from master
   input wire logic       phase, // format
   input wire logic       cpol,  // idle level
   input wire logic [7:0] tx,    // reply byte
   output logic           miso,  // to master
   output logic [7:0]     rx     // received bits
);
   logic [7:0] sr;
   initial miso = 1'b0;
   always @(negedge ss_n) begin
      sr = tx;
      rx = 8'h00;
      if (!phase) miso = sr[7];
   end
   // no pull-up: a released line must not keep the last bit
   always @(posedge ss_n) miso = ~miso;
   always @(sck) if (!ss_n) begin
      if ((sck != cpol) ^ phase) rx = {rx[6:0], mosi};
      else begin
         if (!phase) sr = sr << 1;
         miso = sr[7];
         if (phase) sr = sr << 1;
      end
   end
endmodule // sscc_slave_model

// [spi_shift_and_clock_core_test.sv]
// self-checking bench for the spi shift and clock core
`timescale 1ns/1ps
module spi_shift_and_clock_core_test;
   typedef struct {logic [7:0] rd; logic [7:0] srx; logic [7:0] m;} sscc_note_type;
   sscc_note_type notes[$];
   sscc_note_type nt;
   logic        clock, arst_n, enable, master, multi_m, ss_output, ss_value;
   logic        phase, cpol, wr_strobe, ovr_clear, col_clear, rd_ack;
   logic        b_sck, ss_ext, b_mosi, m_miso, busy, done, rx_full;
   logic        sck_out, sck_oe, ss_n_out, ss_n_oe, mosi_out, mosi_oe;
   logic        miso_out, miso_oe, ovr_flag, col_flag;
   logic [2:0]  len;
   logic [15:0] brg;
   logic [7:0]  wr_data, slave_tx, rnd, rd_data, slave_rx;
   int          err_total, tests_run, i;
   wire logic   sck_pin = sck_oe ? sck_out : b_sck;
   wire logic   ss_pin = ss_n_oe ? ss_n_out : ss_ext;
   wire logic   mosi_pin = mosi_oe ? mosi_out : b_mosi;
   wire logic   miso_pin = miso_oe ? miso_out : m_miso;
   sscc_core i_dut (
      .CLOCK(clock), .ARST_N(arst_n), .ENABLE(enable), .MASTER(master),
      .MULTI_MASTER(multi_m), .SS_OUTPUT(ss_output), .SS_VALUE(ss_value),
      .PHASE(phase), .CLOCK_POLARITY_BIT(cpol), .CHAR_LENGTH_FIELD(len),
      .BRG_RELOAD(brg), .WR_DATA(wr_data), .WR_STROBE(wr_strobe),
      .OVR_CLEAR(ovr_clear), .COL_CLEAR(col_clear), .RD_ACK(rd_ack),
      .SCK_IN(sck_pin), .SS_N_IN(ss_pin), .MOSI_IN(mosi_pin),
      .MISO_IN(miso_pin), .SCK_OUT(sck_out), .SCK_OE(sck_oe),
      .SS_N_OUT(ss_n_out), .SS_N_OE(ss_n_oe), .MOSI_OUT(mosi_out),
      .MOSI_OE(mosi_oe), .MISO_OUT(miso_out), .MISO_OE(miso_oe),
      .RD_DATA(rd_data), .BUSY(busy), .DONE(done), .RX_FULL(rx_full),
      .OVERRUN_FLAG(ovr_flag), .COLLISION_FLAG(col_flag)
   );
   sscc_slave_model i_slave (
      .sck(sck_pin), .ss_n(ss_pin), .mosi(mosi_pin), .phase(phase),
      .cpol(cpol), .tx(slave_tx), .miso(m_miso), .rx(slave_rx)
   );
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask
   task automatic summarize();
      if (err_total == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic xfer(input logic [7:0] d, input logic [7:0] s, input int n,
                       input bit overrun_flag);
      logic [7:0] m;
      int         k;
      m = 8'hff >> (8 - n);
      slave_tx = s;
      len = 3'(n);
      // let a new idle sck level settle before the slave is selected
      tick(2);
      ss_value = 1'b0;
      tick(2);
      notes.push_back('{(s >> (8 - n)) & m, (d >> (8 - n)) & m, m});
      wr_data = d;
      wr_strobe = 1'b1;
      rd_ack = rx_full;
      tick(1);
      {wr_strobe, rd_ack} = 2'b00;
      if (overrun_flag) begin
         tick(4);
         wr_data = ~d;
         wr_strobe = 1'b1;
         tick(1);
         wr_strobe = 1'b0;
      end
      for (k = 0; k < 4000 && done !== 1'b1; k++) tick(1);
      if (k == 4000) begin
         chk(1'b0, "done timeout");
         summarize();
      end
      tick(1);
      ss_value = 1'b1;
      if (overrun_flag) begin
         chk(ovr_flag === 1'b1, "overrun not set");
         ovr_clear = 1'b1;
         tick(1);
         ovr_clear = 1'b0;
         tick(1);
         chk(ovr_flag === 1'b0, "overrun not cleared");
      end
   endtask
   always @(negedge clock) if (done === 1'b1) begin
      if (notes.size() == 0) chk(1'b0, "unexpected done");
      else begin
         nt = notes.pop_front();
         chk((rd_data & nt.m) === nt.rd, "master rx");
         chk((slave_rx & nt.m) === nt.srx, "slave rx");
      end
   end
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      arst_n = 1'b0;
      {enable, master, multi_m, ss_output, phase, cpol} = '0;
      {wr_strobe, ovr_clear, col_clear, rd_ack, b_sck, b_mosi} = '0;
      {ss_value, ss_ext} = 2'b11;
      len = 3'h0;
      // half period well above the 3-flop miso synchroniser delay
      brg = 16'h0008;
      {wr_data, slave_tx} = 16'h0000;
      rnd = 8'h3c;
      err_total = 0;
      tests_run = 0;
      tick(20);
      arst_n = 1'b1;
      {enable, master, ss_output} = 3'b111;
      tick(6);
      for (i = 0; i < 12; i++) begin
         {phase, cpol} = 2'(i);
         rnd = lfsr(rnd);
         xfer(rnd, lfsr(rnd), (i * 3) % 8 + 1, i == 5);
         rnd = lfsr(rnd);
      end
      wr_strobe = 1'b1;
      tick(1);
      wr_strobe = 1'b0;
      tick(3);
      chk(busy === 1'b0, "write taken while unread");
      enable = 1'b0;
      tick(3);
      chk(mosi_oe === 1'b0 && miso_oe === 1'b0, "driven when off");
      {enable, multi_m, ss_output, ss_ext} = 4'b1100;
      tick(10);
      chk(col_flag === 1'b1, "no collision");
      ss_ext = 1'b1;
      tick(6);
      col_clear = 1'b1;
      tick(1);
      col_clear = 1'b0;
      tick(2);
      chk(col_flag === 1'b0, "collision stuck");
      {master, multi_m} = 2'b00;
      repeat (16) begin
         b_sck = ~b_sck;
         tick(5);
      end
      chk(busy === 1'b0 && miso_oe === 1'b0, "unselected slave");
      ss_ext = 1'b0;
      tick(8);
      chk(miso_oe === 1'b1 && mosi_oe === 1'b0, "slave pins");
      summarize();
   end
endmodule // spi_shift_and_clock_core_test
